// File: smvta_defs.svh
// Register offsets, field positions and table sizes of the table access block
`ifndef SMVTA_DEFS_SVH
`define SMVTA_DEFS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define SMVTA_ADDR_W        12
`define SMVTA_OFS_VENT0     12'h400
`define SMVTA_OFS_VENT1     12'h404
`define SMVTA_OFS_VENT2     12'h408
`define SMVTA_OFS_VIDX      12'h40C
`define SMVTA_OFS_VCTL      12'h410
`define SMVTA_OFS_VMODE     12'h414
`define SMVTA_OFS_SCTL      12'h41C
`define SMVTA_OFS_SW1       12'h420
`define SMVTA_OFS_SW2       12'h424
`define SMVTA_OFS_SW3       12'h428
`define SMVTA_OFS_SW4       12'h42C

// ************************************************************
// Field positions
// ************************************************************
`define SMVTA_B_BYPASS      31
`define SMVTA_B_USEGRP      30
`define SMVTA_B_P5FWD       6
`define SMVTA_GO_BIT        7
`define SMVTA_B_SACT        8
`define SMVTA_B_SSEL        9
`define SMVTA_B_VACT        0
`define SMVTA_B_VMODE       0
`define SMVTA_B_VRSVD       6

// ************************************************************
// Table sizes and widths
// ************************************************************
`define SMVTA_STATIC_N      16
`define SMVTA_VLAN_N        4096
`define SMVTA_RSVD_N        6'h30
`define SMVTA_RSVD_GRPS     8
`define SMVTA_RSVD_PER_GRP  6'h06
`define SMVTA_SEL_STATIC    1'h0
`define SMVTA_SEL_RSVD      1'h1
`define SMVTA_ACT_WRITE     1'h0
`define SMVTA_ACT_READ      1'h1

`endif

// File: smvta_pkg.sv
// Types shared by the table access block
package smvta_pkg;

    // Engine state of each indirect access path
    typedef enum logic {SMVTA_IDLE, SMVTA_RUN} smvta_op_e;

    // One static address entry, also the layout of the staging words
    typedef struct packed {
        logic        valid;
        logic        src_drop;
        logic        dst_drop;
        logic [2:0]  prio;
        logic [2:0]  span;
        logic        bypass;
        logic        use_grp;
        logic [4:0]  fwd_mask;
        logic [6:0]  grp_id;
        logic [15:0] mac_hi;
        logic [31:0] mac_lo;
    } smvta_static_s;

    // One VLAN entry
    typedef struct packed {
        logic        valid;
        logic        fwd_opt;
        logic [2:0]  prio;
        logic [2:0]  span;
        logic [6:0]  grp_id;
        logic [7:0]  untag;
        logic [7:0]  member;
    } smvta_vlan_s;

endpackage

// File: smvta_top.sv
// Indirect access to the static, reserved multicast and VLAN tables
//
// Summary of operation
// - Static word two bit 31 lets the entry bypass the port state.
// - Static word two bit 30 makes the group id count for multicast matches.
// - Forward mask: bit 6 is port 5, bits 3:0 ports 4..1; 5:4 read zero.
// - Word three holds group id 22:16 and address 47:32; word four address 31:0.
// - Reserved multicast table covers 48 addresses indexed by low six address bits.
// - The 48 addresses form 8 groups; a mask write changes the whole group.
// - Reserved read with select 1 and read places the entry in word two.
// - Device clears the go bit itself when a static or reserved operation ends.
// - With tagged VLAN mode on, ingress lookups read the VLAN table.
// - VLAN table has 4096 entries; host programs it before enabling the mode.
// - VLAN entry has valid flag and forward option selecting membership forwarding.
// - VLAN entry holds a 3-bit priority and 3-bit spanning instance index.
// - VLAN entry holds a 7-bit filter group id used for address hashing.
// - Untag mask bit one strips the tag at that egress port.
// - VLAN port masks: bit 0 port 1, bit 7 port 5, bit 6 reserved.
// - VLAN write: load words, 12-bit index, write plus go bit 7; device clears.
// - VLAN read: index, read plus go bit 7; words hold the entry after.
`include "smvta_defs.svh"

module smvta_top
    import smvta_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [`SMVTA_ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Ingress VLAN lookup
    input wire logic lookup_req_i,
    input wire logic [11:0] lookup_vid_i,
    output logic lookup_ack_o,
    output logic lookup_valid_o,
    output logic lookup_fwd_opt_o,
    output logic [2:0] lookup_prio_o,
    output logic [2:0] lookup_span_o,
    output logic [6:0] lookup_grp_id_o,
    output logic [7:0] lookup_untag_o,
    output logic [7:0] lookup_member_o
);

    // ************************************************************
    // State
    // ************************************************************
    smvta_static_s stab [`SMVTA_STATIC_N];
    smvta_static_s next_stab [`SMVTA_STATIC_N];
    logic [4:0] rtab [`SMVTA_RSVD_GRPS];
    logic [4:0] next_rtab [`SMVTA_RSVD_GRPS];
    smvta_vlan_s vtab [`SMVTA_VLAN_N];
    smvta_vlan_s next_vtab [`SMVTA_VLAN_N];
    smvta_static_s sreg;
    smvta_static_s next_sreg;
    smvta_vlan_s vreg;
    smvta_vlan_s next_vreg;
    smvta_op_e st_state;
    smvta_op_e next_st_state;
    smvta_op_e vl_state;
    smvta_op_e next_vl_state;
    logic [5:0] s_idx;
    logic [5:0] next_s_idx;
    logic s_sel;
    logic next_s_sel;
    logic s_act;
    logic next_s_act;
    logic [11:0] v_idx;
    logic [11:0] next_v_idx;
    logic v_act;
    logic next_v_act;
    logic vmode;
    logic next_vmode;
    logic [31:0] next_rdata;
    logic next_lk_ack;
    smvta_vlan_s lk;
    smvta_vlan_s next_lk;
    logic [2:0] r_grp;
    logic r_in_range;

    // Reserved address to group; six consecutive indices share a group
    assign r_in_range = (s_idx < `SMVTA_RSVD_N);
    assign r_grp = 3'(s_idx / `SMVTA_RSVD_PER_GRP);

    // ************************************************************
    // Static and reserved multicast engine
    // ************************************************************

    // Staging words, control and table updates; writes dropped while busy
    always_comb
    begin
        next_stab = stab;
        next_rtab = rtab;
        next_sreg = sreg;
        next_st_state = st_state;
        next_s_idx = s_idx;
        next_s_sel = s_sel;
        next_s_act = s_act;
        if (st_state == SMVTA_IDLE && wr_i)
        begin
            unique case (addr_i)
                `SMVTA_OFS_SW1:
                begin
                    next_sreg.valid = wdata_i[31];
                    next_sreg.src_drop = wdata_i[30];
                    next_sreg.dst_drop = wdata_i[29];
                    next_sreg.prio = wdata_i[28:26];
                    next_sreg.span = wdata_i[2:0];
                end
                `SMVTA_OFS_SW2:
                begin
                    next_sreg.bypass = wdata_i[`SMVTA_B_BYPASS];
                    next_sreg.use_grp = wdata_i[`SMVTA_B_USEGRP];
                    next_sreg.fwd_mask = {wdata_i[`SMVTA_B_P5FWD], wdata_i[3:0]};
                end
                `SMVTA_OFS_SW3:
                begin
                    next_sreg.grp_id = wdata_i[22:16];
                    next_sreg.mac_hi = wdata_i[15:0];
                end
                `SMVTA_OFS_SW4: next_sreg.mac_lo = wdata_i;
                `SMVTA_OFS_SCTL:
                begin
                    next_s_idx = wdata_i[5:0];
                    next_s_sel = wdata_i[`SMVTA_B_SSEL];
                    next_s_act = wdata_i[`SMVTA_B_SACT];
                    if (wdata_i[`SMVTA_GO_BIT])
                        next_st_state = SMVTA_RUN;
                end
                default: ;
            endcase
        end
        // One-cycle operation, then go clears itself
        if (st_state == SMVTA_RUN)
        begin
            next_st_state = SMVTA_IDLE;
            if (s_sel == `SMVTA_SEL_STATIC)
            begin
                if (s_act == `SMVTA_ACT_WRITE)
                    next_stab[s_idx[3:0]] = sreg;
                else
                    next_sreg = stab[s_idx[3:0]];
            end
            else if (r_in_range)
            begin
                if (s_act == `SMVTA_ACT_WRITE)
                    next_rtab[r_grp] = sreg.fwd_mask;
                else
                    next_sreg.fwd_mask = rtab[r_grp];
            end
        end
    end

    // ************************************************************
    // VLAN engine
    // ************************************************************

    // Staging words, index, mode and table updates
    always_comb
    begin
        next_vtab = vtab;
        next_vreg = vreg;
        next_vl_state = vl_state;
        next_v_idx = v_idx;
        next_v_act = v_act;
        next_vmode = vmode;
        if (wr_i && addr_i == `SMVTA_OFS_VMODE)
            next_vmode = wdata_i[`SMVTA_B_VMODE];
        if (vl_state == SMVTA_IDLE && wr_i)
        begin
            unique case (addr_i)
                `SMVTA_OFS_VENT0:
                begin
                    next_vreg.valid = wdata_i[0];
                    next_vreg.fwd_opt = wdata_i[1];
                    next_vreg.prio = wdata_i[4:2];
                    next_vreg.span = wdata_i[7:5];
                    next_vreg.grp_id = wdata_i[14:8];
                end
                `SMVTA_OFS_VENT1:
                begin
                    next_vreg.untag = wdata_i[7:0];
                    next_vreg.untag[`SMVTA_B_VRSVD] = 1'b0;
                end
                `SMVTA_OFS_VENT2:
                begin
                    next_vreg.member = wdata_i[7:0];
                    next_vreg.member[`SMVTA_B_VRSVD] = 1'b0;
                end
                `SMVTA_OFS_VIDX: next_v_idx = wdata_i[11:0];
                `SMVTA_OFS_VCTL:
                begin
                    next_v_act = wdata_i[`SMVTA_B_VACT];
                    if (wdata_i[`SMVTA_GO_BIT])
                        next_vl_state = SMVTA_RUN;
                end
                default: ;
            endcase
        end
        if (vl_state == SMVTA_RUN)
        begin
            next_vl_state = SMVTA_IDLE;
            if (v_act == `SMVTA_ACT_WRITE)
                next_vtab[v_idx] = vreg;
            else
                next_vreg = vtab[v_idx];
        end
    end

    // ************************************************************
    // Read data and lookup
    // ************************************************************

    // Read answer exists only in the cycle after the strobe
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (rd_i)
        begin
            unique case (addr_i)
                `SMVTA_OFS_SW1:
                    next_rdata = {sreg.valid, sreg.src_drop, sreg.dst_drop, sreg.prio,
                                  23'h00_0000, sreg.span};
                `SMVTA_OFS_SW2:
                    next_rdata = {sreg.bypass, sreg.use_grp, 23'h00_0000, sreg.fwd_mask[4],
                                  2'h0, sreg.fwd_mask[3:0]};
                `SMVTA_OFS_SW3:
                    next_rdata = {9'h000, sreg.grp_id, sreg.mac_hi};
                `SMVTA_OFS_SW4: next_rdata = sreg.mac_lo;
                `SMVTA_OFS_SCTL:
                    next_rdata = {22'h00_0000, s_sel, s_act, st_state == SMVTA_RUN,
                                  1'h0, s_idx};
                `SMVTA_OFS_VENT0:
                    next_rdata = {17'h0_0000, vreg.grp_id, vreg.span, vreg.prio,
                                  vreg.fwd_opt, vreg.valid};
                `SMVTA_OFS_VENT1: next_rdata = {24'h00_0000, vreg.untag};
                `SMVTA_OFS_VENT2: next_rdata = {24'h00_0000, vreg.member};
                `SMVTA_OFS_VIDX: next_rdata = {20'h0_0000, v_idx};
                `SMVTA_OFS_VCTL:
                    next_rdata = {24'h00_0000, vl_state == SMVTA_RUN, 6'h00, v_act};
                `SMVTA_OFS_VMODE: next_rdata = {31'h0000_0000, vmode};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Lookups answered only in tagged mode; result held until the next one
    always_comb
    begin
        next_lk_ack = lookup_req_i && vmode;
        next_lk = lk;
        if (lookup_req_i && vmode)
            next_lk = vtab[lookup_vid_i];
    end

    // ************************************************************
    // Registers
    // ************************************************************

    // All tables clear at reset so nothing forwards before programming
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            stab <= '{default: '0};
            rtab <= '{default: '0};
            vtab <= '{default: '0};
            sreg <= '0;
            vreg <= '0;
            st_state <= SMVTA_IDLE;
            vl_state <= SMVTA_IDLE;
            s_idx <= 6'h00;
            s_sel <= 1'h0;
            s_act <= 1'h0;
            v_idx <= 12'h000;
            v_act <= 1'h0;
            vmode <= 1'h0;
            rdata_o <= 32'h0000_0000;
            lookup_ack_o <= 1'h0;
            lk <= '0;
        end
        else
        begin
            stab <= next_stab;
            rtab <= next_rtab;
            vtab <= next_vtab;
            sreg <= next_sreg;
            vreg <= next_vreg;
            st_state <= next_st_state;
            vl_state <= next_vl_state;
            s_idx <= next_s_idx;
            s_sel <= next_s_sel;
            s_act <= next_s_act;
            v_idx <= next_v_idx;
            v_act <= next_v_act;
            vmode <= next_vmode;
            rdata_o <= next_rdata;
            lookup_ack_o <= next_lk_ack;
            lk <= next_lk;
        end
    end

    // Lookup result fields
    assign lookup_valid_o = lk.valid;
    assign lookup_fwd_opt_o = lk.fwd_opt;
    assign lookup_prio_o = lk.prio;
    assign lookup_span_o = lk.span;
    assign lookup_grp_id_o = lk.grp_id;
    assign lookup_untag_o = lk.untag;
    assign lookup_member_o = lk.member;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    AST_SGO_SELF_CLEAR: assert property (
        (wr_i && addr_i == `SMVTA_OFS_SCTL && wdata_i[`SMVTA_GO_BIT] && st_state == SMVTA_IDLE)
        |=> st_state == SMVTA_RUN ##1 st_state == SMVTA_IDLE)
        else $error("static go bit did not clear after one busy cycle");

    AST_VGO_SELF_CLEAR: assert property (
        (wr_i && addr_i == `SMVTA_OFS_VCTL && wdata_i[`SMVTA_GO_BIT] && vl_state == SMVTA_IDLE)
        |=> vl_state == SMVTA_RUN ##1 vl_state == SMVTA_IDLE)
        else $error("vlan go bit did not clear after one busy cycle");

    AST_BUSY_READS_ONE: assert property (
        (rd_i && addr_i == `SMVTA_OFS_SCTL && st_state == SMVTA_RUN)
        |=> rdata_o[`SMVTA_GO_BIT])
        else $error("go bit read zero while busy");

    AST_W2_RSVD_ZERO: assert property (
        (rd_i && addr_i == `SMVTA_OFS_SW2) |=> rdata_o[29:7] == '0 && rdata_o[5:4] == '0)
        else $error("reserved bits of word two not zero");

    AST_W3_LAYOUT: assert property (
        (rd_i && addr_i == `SMVTA_OFS_SW3)
        |=> rdata_o[31:23] == '0 && rdata_o[22:16] == $past(sreg.grp_id))
        else $error("word three layout wrong");

    AST_RSVD_GROUP_WRITE: assert property (
        (st_state == SMVTA_RUN && s_sel == `SMVTA_SEL_RSVD && s_act == `SMVTA_ACT_WRITE
         && r_in_range) |=> rtab[$past(r_grp)] == $past(sreg.fwd_mask))
        else $error("reserved group mask not written");

    AST_RSVD_READBACK: assert property (
        (st_state == SMVTA_RUN && s_sel == `SMVTA_SEL_RSVD && s_act == `SMVTA_ACT_READ
         && r_in_range) |=> sreg.fwd_mask == $past(rtab[r_grp]))
        else $error("reserved read did not load word two");

    AST_VLAN_READBACK: assert property (
        (vl_state == SMVTA_RUN && v_act == `SMVTA_ACT_READ) |=> vreg == $past(vtab[v_idx]))
        else $error("vlan read did not load entry words");

    AST_LOOKUP_GATED: assert property (
        (lookup_req_i && !vmode) |=> !lookup_ack_o)
        else $error("lookup answered with tagged mode off");

    AST_VLAN_BIT6_ZERO: assert property (
        (rd_i && (addr_i == `SMVTA_OFS_VENT1 || addr_i == `SMVTA_OFS_VENT2))
        |=> !rdata_o[`SMVTA_B_VRSVD])
        else $error("reserved port mask bit 6 set");

endmodule

// File: tb.sv
// Self-checking bench for the static, reserved multicast and VLAN table access block
`include "smvta_defs.svh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // Clock, reset and design ports
    // ************************************************************
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic lookup_req_i = 1'b0;
    logic [11:0] lookup_vid_i = 12'h000;
    logic lookup_ack_o, lookup_valid_o, lookup_fwd_opt_o;
    logic [2:0] lookup_prio_o, lookup_span_o;
    logic [6:0] lookup_grp_id_o;
    logic [7:0] lookup_untag_o, lookup_member_o;
    int bad_count = 0;
    int checks = 0;
    int seed = 32'h67785D90;

    // Reference model: static words, reserved group masks, VLAN words
    logic [31:0] sm [16][4];
    logic [31:0] rg [8];
    logic [31:0] vw [4096][3];
    logic [30:0] last_lk = 31'h0;

    always #5 sys_clk_i = ~sys_clk_i;

    smvta_top dut (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lookup_req_i(lookup_req_i),
        .lookup_vid_i(lookup_vid_i), .lookup_ack_o(lookup_ack_o),
        .lookup_valid_o(lookup_valid_o), .lookup_fwd_opt_o(lookup_fwd_opt_o),
        .lookup_prio_o(lookup_prio_o), .lookup_span_o(lookup_span_o),
        .lookup_grp_id_o(lookup_grp_id_o), .lookup_untag_o(lookup_untag_o),
        .lookup_member_o(lookup_member_o)
    );

    // ************************************************************
    // Bus and compare tasks
    // ************************************************************
    // Compare and count; an unknown matches only an unknown in the same bit of exp
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // Control write with go, read straight after (busy), then again (done)
    task automatic op(input logic [11:0] a, input logic [31:0] c);
        logic [31:0] d;
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= c;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o & 32'h80, 32'h80, "go not busy");
        rd(a, d);
        chk(d & 32'h80, 32'h0, "go not cleared");
    endtask

    function automatic logic [31:0] sctl(input logic sel, input logic act, input logic [5:0] i);
        return {22'h0, sel, act, 1'b1, 1'b0, i};
    endfunction

    function automatic logic [30:0] lk_exp(input int v);
        return {vw[v][0][0], vw[v][0][1], vw[v][0][4:2], vw[v][0][7:5], vw[v][0][14:8],
                vw[v][1][7:0], vw[v][2][7:0]};
    endfunction

    // Back-to-back lookups; refused ones must leave the fields alone
    task automatic lk(input int vq[$], input logic ack_exp);
        logic [30:0] got;
        @(posedge sys_clk_i);
        lookup_req_i <= 1'b1;
        lookup_vid_i <= vq[0][11:0];
        foreach (vq[k])
        begin
            @(posedge sys_clk_i);
            if (k + 1 < vq.size())
                lookup_vid_i <= vq[k + 1][11:0];
            else
                lookup_req_i <= 1'b0;
            #1 got = {lookup_valid_o, lookup_fwd_opt_o, lookup_prio_o, lookup_span_o,
                      lookup_grp_id_o, lookup_untag_o, lookup_member_o};
            if (ack_exp)
                last_lk = lk_exp(vq[k]);
            chk({31'h0, lookup_ack_o}, {31'h0, ack_exp}, "lookup ack");
            chk({1'b0, got}, {1'b0, last_lk}, "lookup fields");
        end
    endtask

    // ************************************************************
    // Closing and watchdog
    // ************************************************************
    task automatic summarize;
        $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Whole run needs some five hundred cycles; twenty thousand means a hang
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        summarize();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial
    begin
        logic [31:0] d, r;
        logic [11:0] regs [$];
        int iq [$];
        logic [5:0] ri;
        foreach (sm[i, j]) sm[i][j] = 32'h0;
        foreach (vw[i, j]) vw[i][j] = 32'h0;
        foreach (rg[i]) rg[i] = 32'h0;
        repeat (12) @(posedge sys_clk_i);
        nrst_i <= 1'b1;

        // Reset values and unmapped places read zero
        regs = '{`SMVTA_OFS_VENT0, `SMVTA_OFS_VENT1, `SMVTA_OFS_VENT2, `SMVTA_OFS_VIDX,
                 `SMVTA_OFS_VCTL, `SMVTA_OFS_VMODE, `SMVTA_OFS_SCTL, `SMVTA_OFS_SW1,
                 `SMVTA_OFS_SW2, `SMVTA_OFS_SW3, `SMVTA_OFS_SW4, 12'h418, 12'h430, 12'h000};
        wr(12'h430, 32'hFFFFFFFF);
        foreach (regs[i])
        begin
            rd(regs[i], d);
            chk(d, 32'h0, "reset or unmapped read");
        end
        // Unprogrammed static entry and reserved group read back as zero
        op(`SMVTA_OFS_SCTL, sctl(1'b0, 1'b1, 6'h05));
        for (int w = 0; w < 4; w++)
        begin
            rd(`SMVTA_OFS_SW1 + 12'(4 * w), d);
            chk(d, 32'h0, "static entry after reset");
        end
        op(`SMVTA_OFS_SCTL, sctl(1'b1, 1'b1, 6'h2F));
        rd(`SMVTA_OFS_SW2, d);
        chk(d, 32'h0, "reserved group after reset");
        wr(`SMVTA_OFS_VMODE, 32'h1);
        lk('{$random(seed) & 32'hFFF}, 1'b1);
        $display("Test reset values done");

        // Static table: write edge and four fixed inner indices, read back in reverse
        iq = '{0, 15, 3, 7, 9, 12};
        foreach (iq[k])
        begin
            for (int w = 0; w < 4; w++)
            begin
                r = $random(seed);
                wr(`SMVTA_OFS_SW1 + 12'(4 * w), r);
                sm[iq[k]][w] = r & ((w == 0) ? 32'hFC000007 : (w == 1) ? 32'hC000004F :
                                    (w == 2) ? 32'h007FFFFF : 32'hFFFFFFFF);
            end
            op(`SMVTA_OFS_SCTL, sctl(1'b0, 1'b0, 6'(iq[k])));
        end
        for (int k = iq.size() - 1; k >= 0; k--)
        begin
            op(`SMVTA_OFS_SCTL, sctl(1'b0, 1'b1, 6'(iq[k])));
            for (int w = 0; w < 4; w++)
            begin
                rd(`SMVTA_OFS_SW1 + 12'(4 * w), d);
                chk(d, sm[iq[k]][w], "static entry word");
            end
        end
        // Data write in the busy cycle after go is dropped, staged word kept
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= `SMVTA_OFS_SCTL;
        wdata_i <= sctl(1'b0, 1'b0, 6'h05);
        @(posedge sys_clk_i);
        addr_i <= `SMVTA_OFS_SW4;
        wdata_i <= ~sm[0][3];
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        rd(`SMVTA_OFS_SW4, d);
        chk(d, sm[0][3], "write taken while busy");
        $display("Test static table done");

        // Reserved multicast: write one random member per group, read back through a random member
        for (int g = 0; g < 8; g++)
        begin
            r = $random(seed);
            ri = 6'(g * 6 + r[15:0] % 6);
            r = $random(seed);
            wr(`SMVTA_OFS_SW2, r);
            rg[g] = r & 32'h0000004F;
            op(`SMVTA_OFS_SCTL, sctl(1'b1, 1'b0, ri));
        end
        for (int g = 7; g >= 0; g--)
        begin
            r = $random(seed);
            ri = 6'(g * 6 + r[15:0] % 6);
            r = $random(seed);
            wr(`SMVTA_OFS_SW2, r);
            op(`SMVTA_OFS_SCTL, sctl(1'b1, 1'b1, ri));
            rd(`SMVTA_OFS_SW2, d);
            chk(d, (r & 32'hC0000000) | rg[g], "reserved group mask");
        end
        // Index beyond the 48 addresses leaves the staging word alone
        op(`SMVTA_OFS_SCTL, sctl(1'b1, 1'b1, 6'h32));
        rd(`SMVTA_OFS_SW2, d);
        chk(d, (r & 32'hC0000000) | rg[0], "reserved index out of range");
        $display("Test reserved multicast done");

        // VLAN table: program edge and random ids with mode off, read back
        wr(`SMVTA_OFS_VMODE, 32'h0);
        iq = '{0, 4095};
        for (int k = 0; k < 4; k++) iq.push_back($random(seed) & 32'hFFF);
        foreach (iq[k])
        begin
            for (int w = 0; w < 3; w++)
            begin
                r = $random(seed);
                wr(`SMVTA_OFS_VENT0 + 12'(4 * w), r);
                vw[iq[k]][w] = r & ((w == 0) ? 32'h00007FFF : 32'h000000BF);
            end
            wr(`SMVTA_OFS_VIDX, 32'(iq[k]));
            op(`SMVTA_OFS_VCTL, 32'h80);
        end
        for (int k = iq.size() - 1; k >= 0; k--)
        begin
            wr(`SMVTA_OFS_VIDX, 32'(iq[k]));
            op(`SMVTA_OFS_VCTL, 32'h81);
            for (int w = 0; w < 3; w++)
            begin
                rd(`SMVTA_OFS_VENT0 + 12'(4 * w), d);
                chk(d, vw[iq[k]][w], "VLAN entry word");
            end
        end
        // Lookups refused with mode off, then taken back to back
        lk('{iq[2]}, 1'b0);
        wr(`SMVTA_OFS_VMODE, 32'h1);
        lk(iq, 1'b1);
        wr(`SMVTA_OFS_VMODE, 32'h0);
        lk('{iq[0], iq[3]}, 1'b0);
        $display("Test VLAN table done");
        summarize();
    end
endmodule
